// [core/delivery_status_report_responder.sv]
// response generator for the framed ascii host link of a delivery totaliser
// assumes a frame parser delivers decoded commands and a uart drains tx bytes
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R01: status reply is ID, S, two digits
// R02: hand-held mode completion codes 00 01 08 10
// R03: batch phases give 02 03 04 05
// R04: auto flow 06, flow alarm 07
// R05: setup modes 12, display test 13
// R06: 14 only for totals or print request
// R07: 09 and 11 never without printer
// R08: printer mode 00 and 01 after original
// R09: 08/09 before printing; hand-held then silent; code gives 08 while prn_orig_busy and 09 while prn_dup_busy
// R10: printer mode 10 and 11 on failures
// R11: setup modes answer every command with status
// R12: preset commands valid only in preset mode
// R13: density commands valid only for LPG/petroleum
// R14: totals preset and gross/temp are optional
// R15: auxiliary report field order fixed
// R16: clock report field order fixed
// R17: date format code 0 or 1
// R18: checksum before CR LF on three reports
// R19: variable text fields separated by spaces
// R20: rate reply, temperature only when compensated
// R21: preset and density query reply layouts
// R22: printer flags; block start until original printed
// R23: checksum makes byte sum zero
// R24: every reply ends CR LF
// R25: status as two ascii decimal digits
module delivery_status_report_responder
  import dsr_pkg::*;
#(
  parameter int FIELDS = 32,
  parameter int FIELD_CHARS = 8
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // decoded command from the frame parser
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  output logic cmd_ready,
  // reply byte stream
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // delivery and printer state
  input wire logic [2:0] phase,
  input wire logic deliv_start,
  input wire logic below_min,
  input wire logic hh_comm_err,
  input wire logic prn_orig_busy,
  input wire logic prn_dup_busy,
  input wire logic prn_orig_done,
  input wire logic prn_fail,
  input wire logic prn_timeout,
  input wire logic paper_out,
  // actions to the rest of the unit
  output logic act_tc,
  output logic act_stop,
  output logic act_start,
  output logic act_print,
  output logic start_block
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (FIELDS != 32 || FIELD_CHARS != 8) begin : g_bad_geometry
    $error("field memory geometry must be 32 fields of 8 characters");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ITEM = 3'b001,
    S_BODY = 3'b010,
    S_D1 = 3'b011,
    S_D0 = 3'b100,
    S_LF = 3'b101,
    S_DONE = 3'b110
  } tx_state_e;

  logic [7:0] fld_mem [0:FIELDS*FIELD_CHARS-1];
  logic [CTRL_W-1:0] ctrl_r;
  logic [1:0] prn_flags_r;
  logic report_sent_r;
  logic tc_acked_r;
  logic orig_printed_r;
  logic dup_failed_r;
  tx_state_e st_r, st_nxt;
  reply_e rt_r;
  logic [3:0] it_r, it_nxt;
  logic [2:0] ch_r, ch_nxt;
  logic [7:0] sum_r;
  logic [3:0] code_r;
  logic [7:0] tx_data_nxt;
  logic emit;
  logic step;
  logic [4:0] item;
  logic [7:0] fld_byte;
  logic [3:0] status_now;
  logic wr_flags;
  logic finish;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // item sequence of each reply kind
  function automatic logic [4:0] script(input reply_e rt, input logic [3:0] i);
    logic [4:0] r;
    r = I_END;
    case (rt)
      RT_STATUS: r = (i == 4'd0) ? F_ID : (i == 4'd1) ? I_STAT : I_END; // R01
      RT_TOTALS: begin
        case (i)
          4'd0: r = F_ID;
          4'd1: r = F_DELNO;
          4'd2: r = F_NET;
          4'd3: r = F_NET_ACC;
          4'd4: r = F_GROSS;
          4'd5: r = F_GROSS_ACC;
          4'd6: r = F_TEMP;
          4'd7: r = F_PRESET;
          4'd8: r = F_TRUCK;
          4'd9: r = I_CSUM; // R18
          default: r = I_END;
        endcase
      end
      RT_AUX: begin
        case (i) // R15
          4'd0: r = F_ID;
          4'd1: r = F_END_DATE;
          4'd2: r = F_START_TIME;
          4'd3: r = F_FINISH_TIME;
          4'd4: r = F_METER;
          4'd5: r = F_UNITS;
          4'd6: r = I_CSUM; // R18
          default: r = I_END;
        endcase
      end
      RT_CLOCK: begin
        case (i) // R16
          4'd0: r = F_ID;
          4'd1: r = F_CUR_DATE;
          4'd2: r = F_CUR_TIME;
          4'd3: r = I_FMT;
          4'd4: r = I_CSUM; // R18
          default: r = I_END;
        endcase
      end
      RT_RATE: r = (i == 4'd0) ? F_ID : (i == 4'd1) ? F_RATE : (i == 4'd2) ? F_TEMP : I_END; // R20
      RT_PRESET: r = (i == 4'd0) ? F_ID : (i == 4'd1) ? F_PRESET : I_END; // R21
      RT_DENS: r = (i == 4'd0) ? F_ID : (i == 4'd1) ? F_DENSITY : I_END; // R21
      RT_INVALID: r = (i == 4'd0) ? F_ID : (i == 4'd1) ? I_INV : I_END;
      default: r = I_END;
    endcase
    return r;
  endfunction : script

  // ascii digit of a value below ten
  function automatic logic [7:0] digit(input logic [3:0] v);
    return CH_ZERO + {4'h0, v};
  endfunction : digit

  // ----------------------------------------------------------------
  // status number from delivery and printer state
  // ----------------------------------------------------------------
  always_comb begin
    status_now = ST_READY;
    if (ctrl_r[CTRL_SETUP_BUSY]) begin
      status_now = ST_BUSY; // R05
    end else if (ctrl_r[CTRL_TEST]) begin
      status_now = ST_TEST; // R05
    end else begin
      case (phase_e'(phase))
        PH_SLOW: status_now = ST_SLOW; // R03
        PH_PRESTOP: status_now = ST_PRESTOP; // R03
        PH_FULL: status_now = ST_FULL; // R03
        PH_ENDING: status_now = ST_ENDING; // R03
        PH_AUTOFLOW: status_now = ST_AUTOFLOW; // R04
        PH_ALARM: status_now = ST_ALARM; // R04
        PH_COMPLETE: begin
          if (ctrl_r[CTRL_PRINTER]) begin
            if (prn_orig_busy) begin
              status_now = ST_WAIT_REQ; // R09
            end else if (prn_dup_busy) begin
              status_now = ST_PRN_DUP; // R09
            end else if (!orig_printed_r) begin
              status_now = ST_UNSENT; // R10
            end else if (dup_failed_r) begin
              status_now = ST_DUP_FAIL; // R10
            end else begin
              status_now = tc_acked_r ? ST_READY : ST_WAIT_TC; // R08
            end
          end else begin
            // 09 and 11 are unreachable on this branch
            if (hh_comm_err) begin
              status_now = ST_UNSENT; // R02 R07
            end else if (!report_sent_r) begin
              status_now = ST_WAIT_REQ; // R02
            end else begin
              status_now = tc_acked_r ? ST_READY : ST_WAIT_TC; // R02
            end
          end
        end
        default: status_now = ST_READY;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  assign wr_flags = ce && reg_wr && reg_addr == ADDR_PRN_FLAGS;

  // control register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (ce && reg_wr && reg_addr == ADDR_CTRL) begin
      ctrl_r <= reg_wdata[CTRL_W-1:0];
    end
  end

  // field text memory, written by software; zero bytes are skipped
  always_ff @(posedge clk_sys) begin
    if (ce && reg_wr && reg_addr[11:8] == FIELD_PAGE) begin
      fld_mem[reg_addr[7:0]] <= reg_wdata[7:0];
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        if (reg_addr == ADDR_CTRL) begin
          reg_rdata[CTRL_W-1:0] <= ctrl_r;
        end else if (reg_addr == ADDR_STATUS) begin
          reg_rdata[3:0] <= status_now;
          reg_rdata[STS_REPORT_SENT] <= report_sent_r;
          reg_rdata[STS_TC_ACKED] <= tc_acked_r;
          reg_rdata[STS_ORIG_PRINTED] <= orig_printed_r;
          reg_rdata[STS_DUP_FAILED] <= dup_failed_r;
          reg_rdata[STS_START_BLOCK] <= start_block;
        end else if (reg_addr == ADDR_PRN_FLAGS) begin
          reg_rdata[1:0] <= prn_flags_r;
        end else if (reg_addr[11:8] == FIELD_PAGE) begin
          reg_rdata[7:0] <= fld_mem[reg_addr[7:0]];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // printer error flags, sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prn_flags_r <= 2'h0;
    end else if (ce) begin
      prn_flags_r[PF_TIMEOUT] <= prn_timeout ||
        (prn_flags_r[PF_TIMEOUT] && !(wr_flags && reg_wdata[PF_TIMEOUT])); // R22
      prn_flags_r[PF_PAPER_OUT] <= paper_out ||
        (prn_flags_r[PF_PAPER_OUT] && !(wr_flags && reg_wdata[PF_PAPER_OUT])); // R22
    end
  end

  // ----------------------------------------------------------------
  // delivery bookkeeping; a new delivery clears, events win
  // ----------------------------------------------------------------
  assign finish = step && st_r == S_LF;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      report_sent_r <= 1'b0;
      tc_acked_r <= 1'b0;
      orig_printed_r <= 1'b1;
      dup_failed_r <= 1'b0;
    end else if (ce) begin
      if (finish && rt_r == RT_TOTALS) begin
        report_sent_r <= 1'b1;
      end else if (deliv_start) begin
        report_sent_r <= 1'b0;
      end
      if (cmd_valid && cmd_ready && cmd_code == CMD_TC) begin
        tc_acked_r <= 1'b1;
      end else if (deliv_start) begin
        tc_acked_r <= 1'b0;
      end
      if (prn_orig_done) begin
        orig_printed_r <= 1'b1;
      end else if (deliv_start) begin
        orig_printed_r <= 1'b0;
      end
      if (prn_fail && prn_dup_busy) begin
        dup_failed_r <= 1'b1;
      end else if (deliv_start || prn_dup_busy) begin
        dup_failed_r <= 1'b0;
      end
    end
  end

  // start is refused while the original ticket is still owed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_block <= 1'b0;
    end else if (ce) begin
      start_block <= ctrl_r[CTRL_PRINTER] && !orig_printed_r &&
        phase_e'(phase) == PH_COMPLETE; // R22
    end
  end

  // ----------------------------------------------------------------
  // command decode and action strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rt_r <= RT_STATUS;
      code_r <= ST_READY;
      act_tc <= 1'b0;
      act_stop <= 1'b0;
      act_start <= 1'b0;
      act_print <= 1'b0;
    end else if (ce) begin
      act_tc <= 1'b0;
      act_stop <= 1'b0;
      act_start <= 1'b0;
      act_print <= 1'b0;
      if (cmd_valid && cmd_ready) begin
        code_r <= status_now;
        rt_r <= RT_STATUS;
        if (ctrl_r[CTRL_SETUP_BUSY]) begin
          rt_r <= RT_STATUS; // R11
        end else begin
          case (cmd_e'(cmd_code))
            CMD_TC: act_tc <= 1'b1;
            CMD_STOP: act_stop <= 1'b1;
            CMD_START: act_start <= !start_block; // R22
            CMD_PRINT: begin
              if (!ctrl_r[CTRL_PRINTER]) begin
                rt_r <= RT_INVALID;
              end else if (below_min) begin
                code_r <= ST_NO_REPORT; // R06
              end else begin
                act_print <= 1'b1;
              end
            end
            CMD_TOTALS: begin
              if (below_min) begin
                code_r <= ST_NO_REPORT; // R06
              end else begin
                rt_r <= RT_TOTALS;
              end
            end
            CMD_PRESET_WR, CMD_PRESET_Q:
              rt_r <= ctrl_r[CTRL_PRESET] ? RT_PRESET : RT_INVALID; // R12
            CMD_DENS_WR, CMD_DENS_Q:
              rt_r <= ctrl_r[CTRL_LPG_PET] ? RT_DENS : RT_INVALID; // R13
            CMD_AUX: rt_r <= RT_AUX;
            CMD_CLOCK: rt_r <= RT_CLOCK;
            CMD_RATE: rt_r <= RT_RATE;
            CMD_STATUS: rt_r <= RT_STATUS;
            default: rt_r <= RT_INVALID;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // reply byte engine
  // ----------------------------------------------------------------
  assign step = ce && (!tx_valid || tx_ready);
  assign item = script(rt_r, it_r);
  assign fld_byte = fld_mem[{item, ch_r}];

  // next byte and next position of the reply walk
  always_comb begin
    st_nxt = st_r;
    it_nxt = it_r;
    ch_nxt = ch_r;
    emit = 1'b0;
    tx_data_nxt = CH_NUL;
    case (st_r)
      S_IDLE: begin
        it_nxt = 4'd0;
        ch_nxt = 3'd0;
        if (cmd_valid && cmd_ready) begin
          st_nxt = S_DONE; // one cycle to settle the decode
        end
      end
      S_DONE: st_nxt = S_ITEM;
      S_ITEM: begin
        ch_nxt = 3'd0;
        if (item == I_END) begin
          emit = 1'b1;
          tx_data_nxt = CH_CR; // R24
          st_nxt = S_LF;
        end else if ((item == F_PRESET && rt_r == RT_TOTALS && !ctrl_r[CTRL_PRESET]) ||
                     ((item == F_GROSS || item == F_GROSS_ACC || item == F_TEMP) &&
                      !ctrl_r[CTRL_TCOMP])) begin
          it_nxt = it_r + 4'd1; // R14 R20
        end else begin
          emit = it_r != 4'd0;
          tx_data_nxt = CH_SPACE; // R19
          st_nxt = S_BODY;
        end
      end
      S_BODY: begin
        emit = 1'b1;
        st_nxt = S_ITEM;
        it_nxt = it_r + 4'd1;
        case (item)
          I_STAT: begin
            tx_data_nxt = CH_S; // R01
            st_nxt = S_D1;
            it_nxt = it_r;
          end
          I_FMT: tx_data_nxt = ctrl_r[CTRL_DATE_USA] ? CH_ONE : CH_ZERO; // R17
          I_CSUM: tx_data_nxt = 8'h00 - sum_r; // R23
          I_INV: tx_data_nxt = CH_QUERY;
          default: begin
            emit = fld_byte != CH_NUL; // R19
            tx_data_nxt = fld_byte;
            ch_nxt = ch_r + 3'd1;
            if (ch_r != 3'(FIELD_CHARS - 1)) begin
              st_nxt = S_BODY;
              it_nxt = it_r;
            end
          end
        endcase
      end
      S_D1: begin
        emit = 1'b1;
        tx_data_nxt = (code_r >= 4'd10) ? CH_ONE : CH_ZERO; // R25
        st_nxt = S_D0;
      end
      S_D0: begin
        emit = 1'b1;
        tx_data_nxt = digit((code_r >= 4'd10) ? code_r - 4'd10 : code_r); // R25
        st_nxt = S_ITEM;
        it_nxt = it_r + 4'd1;
      end
      S_LF: begin
        emit = 1'b1;
        tx_data_nxt = CH_LF; // R24
        st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // walk position, a new command is taken only when idle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      it_r <= 4'd0;
      ch_r <= 3'd0;
      cmd_ready <= 1'b0;
    end else if (ce) begin
      cmd_ready <= (st_nxt == S_IDLE) && step && !emit && !(cmd_valid && cmd_ready);
      if (step) begin
        st_r <= st_nxt;
        it_r <= it_nxt;
        ch_r <= ch_nxt;
      end
    end
  end

  // running byte sum for the checksum; cleared at each new reply
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sum_r <= 8'h00;
    end else if (step) begin
      if (st_r == S_IDLE) begin
        sum_r <= 8'h00;
      end else if (emit) begin
        sum_r <= sum_r + tx_data_nxt; // R23
      end
    end
  end

  // output byte register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (step) begin
      tx_valid <= emit;
      if (emit) begin
        tx_data <= tx_data_nxt;
      end
    end
  end

endmodule : delivery_status_report_responder
`default_nettype wire

// [include/dsr_pkg.sv]
// package for the delivery status report responder
// assumes one system clock domain and the single design file under core/
package dsr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PRN_FLAGS = 12'h008;
  localparam logic [3:0] FIELD_PAGE = 4'h1; // 0x100..0x1ff field text bytes

  // control register bits
  localparam int CTRL_PRINTER = 0;
  localparam int CTRL_PRESET = 1;
  localparam int CTRL_TCOMP = 2;
  localparam int CTRL_LPG_PET = 3;
  localparam int CTRL_DATE_USA = 4;
  localparam int CTRL_SETUP_BUSY = 5;
  localparam int CTRL_TEST = 6;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

  // status register bit positions
  localparam int STS_REPORT_SENT = 8;
  localparam int STS_TC_ACKED = 9;
  localparam int STS_ORIG_PRINTED = 10;
  localparam int STS_DUP_FAILED = 11;
  localparam int STS_START_BLOCK = 12;

  // printer flag bits (write one to clear)
  localparam int PF_TIMEOUT = 0;
  localparam int PF_PAPER_OUT = 1;

  // ----------------------------------------------------------------
  // status numbers
  // ----------------------------------------------------------------
  localparam logic [3:0] ST_READY = 4'h0;
  localparam logic [3:0] ST_WAIT_TC = 4'h1;
  localparam logic [3:0] ST_SLOW = 4'h2;
  localparam logic [3:0] ST_PRESTOP = 4'h3;
  localparam logic [3:0] ST_FULL = 4'h4;
  localparam logic [3:0] ST_ENDING = 4'h5;
  localparam logic [3:0] ST_AUTOFLOW = 4'h6;
  localparam logic [3:0] ST_ALARM = 4'h7;
  localparam logic [3:0] ST_WAIT_REQ = 4'h8;
  localparam logic [3:0] ST_PRN_DUP = 4'h9;
  localparam logic [3:0] ST_UNSENT = 4'ha;
  localparam logic [3:0] ST_DUP_FAIL = 4'hb;
  localparam logic [3:0] ST_BUSY = 4'hc;
  localparam logic [3:0] ST_TEST = 4'hd;
  localparam logic [3:0] ST_NO_REPORT = 4'he;

  // delivery phase reported by the metering logic
  typedef enum logic [2:0] {
    PH_COMPLETE = 3'b000,
    PH_SLOW = 3'b001,
    PH_PRESTOP = 3'b010,
    PH_FULL = 3'b011,
    PH_ENDING = 3'b100,
    PH_AUTOFLOW = 3'b101,
    PH_ALARM = 3'b110
  } phase_e;

  // decoded commands from the frame parser
  typedef enum logic [3:0] {
    CMD_STATUS = 4'h0,
    CMD_TC = 4'h1,
    CMD_PRESET_WR = 4'h2,
    CMD_PRESET_Q = 4'h3,
    CMD_DENS_WR = 4'h4,
    CMD_DENS_Q = 4'h5,
    CMD_PRINT = 4'h6,
    CMD_TOTALS = 4'h7,
    CMD_AUX = 4'h8,
    CMD_CLOCK = 4'h9,
    CMD_RATE = 4'ha,
    CMD_STOP = 4'hb,
    CMD_START = 4'hc,
    CMD_OTHER = 4'hf
  } cmd_e;

  // reply kinds
  typedef enum logic [2:0] {
    RT_STATUS = 3'b000,
    RT_TOTALS = 3'b001,
    RT_AUX = 3'b010,
    RT_CLOCK = 3'b011,
    RT_RATE = 3'b100,
    RT_PRESET = 3'b101,
    RT_DENS = 3'b110,
    RT_INVALID = 3'b111
  } reply_e;

  // ----------------------------------------------------------------
  // reply items: text fields 0..17, then special tokens
  // ----------------------------------------------------------------
  localparam logic [4:0] F_ID = 5'd0;
  localparam logic [4:0] F_DELNO = 5'd1;
  localparam logic [4:0] F_NET = 5'd2;
  localparam logic [4:0] F_NET_ACC = 5'd3;
  localparam logic [4:0] F_GROSS = 5'd4;
  localparam logic [4:0] F_GROSS_ACC = 5'd5;
  localparam logic [4:0] F_TEMP = 5'd6;
  localparam logic [4:0] F_PRESET = 5'd7;
  localparam logic [4:0] F_TRUCK = 5'd8;
  localparam logic [4:0] F_END_DATE = 5'd9;
  localparam logic [4:0] F_START_TIME = 5'd10;
  localparam logic [4:0] F_FINISH_TIME = 5'd11;
  localparam logic [4:0] F_METER = 5'd12;
  localparam logic [4:0] F_UNITS = 5'd13;
  localparam logic [4:0] F_CUR_DATE = 5'd14;
  localparam logic [4:0] F_CUR_TIME = 5'd15;
  localparam logic [4:0] F_RATE = 5'd16;
  localparam logic [4:0] F_DENSITY = 5'd17;
  localparam logic [4:0] I_STAT = 5'd24;
  localparam logic [4:0] I_FMT = 5'd25;
  localparam logic [4:0] I_CSUM = 5'd26;
  localparam logic [4:0] I_INV = 5'd27;
  localparam logic [4:0] I_END = 5'd31;

  // ----------------------------------------------------------------
  // ascii characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_NUL = 8'h00;

endpackage : dsr_pkg

// [tb/dsr_asserts.sv]
// port checker for the status report responder
// assumes one clock domain; bound to the responder below
`timescale 1ns/1ps
`default_nettype none
module dsr_asserts
  import dsr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // ports watched
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic act_tc,
  input wire logic act_stop,
  input wire logic act_start,
  input wire logic act_print
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----
  // relations
  // ----
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte changed while stalled");
  a_take_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready stayed high after take");
  a_idle_quiet: assert property (cmd_ready |-> !tx_valid)
    else $error("byte sent while idle");
  a_crlf_pair: assert property (tx_valid && tx_ready && tx_data == CH_CR |=>
    tx_valid && tx_data == CH_LF) else $error("return not followed by line feed");
  a_reply_soon: assert property (cmd_valid && cmd_ready |-> ##[3:40] tx_valid)
    else $error("reply did not start");
  a_tc_pulse: assert property (act_tc |=> !act_tc)
    else $error("action pulse too long");
  a_act_onehot: assert property ($onehot0({act_tc, act_stop, act_start, act_print}))
    else $error("two actions at once");
  c_take: cover property (cmd_valid && cmd_ready);
  c_stall: cover property (tx_valid && !tx_ready);
  c_tc: cover property (act_tc);
endmodule : dsr_asserts
bind delivery_status_report_responder dsr_asserts chk_u (.clk_sys, .rst_n, .reg_rd,
  .reg_rdata, .cmd_valid, .cmd_ready, .tx_data, .tx_valid, .tx_ready, .act_tc,
  .act_stop, .act_start, .act_print);
`default_nettype wire

// [tb/hh_model.sv]
// hand-held computer model: collects the reply bytes
// assumes the bench drives stall to make it slow
`timescale 1ns/1ps
`default_nettype none
module hh_model (
  // link
  input wire logic clk_sys,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // control
  input wire logic stall
);
  logic [7:0] rx[$];
  // ready falls while stalled
  assign tx_ready = !stall;
  // keep each byte taken
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) rx.push_back(tx_data);
  end
endmodule : hh_model
`default_nettype wire

// [tb/tb.sv]
// bench for the status report responder
// assumes the checker and the hand-held model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dsr_pkg::*;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cmd_valid = 0, stall = 0, slow = 0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [3:0] cmd_code = 4'h0, lv = 4'h0; // below_min comm_err orig_busy dup_busy
  logic [2:0] phase = 3'h0;
  logic [4:0] pl = 5'h00; // start orig_done fail timeout paper
  logic cmd_ready, tx_valid, tx_ready, act_tc, act_stop, act_start, act_print, start_block;
  logic [7:0] tx_data;
  int fails = 0, n_tests = 0;
  initial forever #50 clk_sys = ~clk_sys;
  // slow partner: ready every other cycle
  always @(posedge clk_sys) stall <= slow & ~stall;
  delivery_status_report_responder dut_u (.clk_sys, .rst_n, .ce(1'b1), .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_valid, .cmd_code, .cmd_ready,
    .tx_data, .tx_valid, .tx_ready, .phase, .deliv_start(pl[4]), .below_min(lv[3]),
    .hh_comm_err(lv[2]), .prn_orig_busy(lv[1]), .prn_dup_busy(lv[0]),
    .prn_orig_done(pl[3]), .prn_fail(pl[2]), .prn_timeout(pl[1]), .paper_out(pl[0]),
    .act_tc, .act_stop, .act_start, .act_print, .start_block);
  hh_model hh_u (.clk_sys, .tx_data, .tx_valid, .tx_ready, .stall);
  // ----
  // shared tasks
  // ----
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wait_ready();
    int i;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 400) begin
      @(posedge clk_sys);
      #1 i++;
    end
    if (i == 400) begin
      fails++;
      results();
    end
  endtask : wait_ready
  // one command, then compare the whole reply unless e is empty
  task automatic send(input cmd_e c, input string e);
    string s;
    hh_u.rx.delete();
    @(posedge clk_sys);
    cmd_code <= c;
    cmd_valid <= 1'b1;
    #1 wait_ready();
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1 wait_ready();
    s = "";
    foreach (hh_u.rx[k]) s = {s, string'(hh_u.rx[k])};
    if (e.len() > 0) check(s == e, "reply text");
  endtask : send
  task automatic st(input cmd_e c, input logic [6:0] k, input logic [2:0] p,
      input logic [3:0] l, input int n);
    wr(ADDR_CTRL, {25'h0, k});
    phase <= p;
    lv <= l;
    send(c, $sformatf("1 S%02d\r\n", n));
  endtask : st
  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] d;
    int s;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 256; i++) wr(12'(12'h100 + i), (i == 0) ? 32'h31 : 32'h0);
    rd(ADDR_STATUS, d);
    check(d[10] === 1'b1 && d[3:0] === 4'h8, "status after reset");
    rd(12'h00c, d);
    check(d === 32'h0, "unmapped read");
    st(CMD_STATUS, 7'h00, 3'h0, 4'h0, 8);
    for (int p = 1; p < 7; p++) st(CMD_STATUS, 7'h00, p[2:0], 4'h0, p + 1);
    slow <= 1'b1;
    st(CMD_STATUS, 7'h00, 3'h0, 4'h1, 8);
    slow <= 1'b0;
    st(CMD_STATUS, 7'h00, 3'h0, 4'h4, 10);
    st(CMD_TOTALS, 7'h00, 3'h0, 4'h8, 14);
    st(CMD_RATE, 7'h20, 3'h0, 4'h0, 12);
    st(CMD_STATUS, 7'h40, 3'h0, 4'h0, 13);
    st(CMD_STATUS, 7'h01, 3'h0, 4'h0, 1);
    st(CMD_STATUS, 7'h01, 3'h0, 4'h2, 8);
    st(CMD_STATUS, 7'h01, 3'h0, 4'h1, 9);
    send(CMD_TC, "");
    st(CMD_STATUS, 7'h01, 3'h0, 4'h0, 0);
    pl <= 5'h13;
    @(posedge clk_sys);
    pl <= 5'h00;
    repeat (2) @(posedge clk_sys);
    check(start_block === 1'b1, "start not blocked");
    rd(ADDR_PRN_FLAGS, d);
    check(d[1:0] === 2'b11, "printer flags");
    wr(ADDR_PRN_FLAGS, 32'h3);
    rd(ADDR_PRN_FLAGS, d);
    check(d[1:0] === 2'b00, "flags not cleared");
    pl <= 5'h08;
    @(posedge clk_sys);
    pl <= 5'h00;
    repeat (2) @(posedge clk_sys);
    check(start_block === 1'b0, "block kept");
    wr(ADDR_CTRL, 32'h10);
    send(CMD_CLOCK, "");
    s = 0;
    foreach (hh_u.rx[k]) if (k < hh_u.rx.size() - 2) s += hh_u.rx[k];
    check(s[7:0] === 8'h00, "checksum");
    check(hh_u.rx[hh_u.rx.size() - 5] === CH_ONE, "date format");
    check(hh_u.rx[hh_u.rx.size() - 1] === CH_LF, "line end");
    wr(ADDR_CTRL, 32'h0);
    send(CMD_PRESET_Q, "1 ?\r\n");
    send(CMD_DENS_Q, "1 ?\r\n");
    results();
  end
endmodule : tb
`default_nettype wire
